// ---- pkg/dmab_pkg.sv ----
// constants, types and helpers shared by the channel b control block
package dmab_pkg;

  // ********
  // bus and register map
  // ********
  localparam int          WB_AW       = 8;      // byte address width
  localparam int          WB_DW       = 32;     // data width
  localparam logic [7:0]  IDX_COUNT   = 8'h2C;  // transfer count, index
  localparam logic [7:0]  IDX_IOADDR  = 8'h2E;  // i/o address, index
  localparam logic [7:0]  IDX_CTRL    = 8'h2F;  // control register, index
  localparam logic [7:0]  IDX_MADDR   = 8'h30;  // memory address, index
  localparam logic [7:0]  IDX_STAT    = 8'h31;  // interrupt status, index
  localparam logic [7:0]  IDX_MASK    = 8'h32;  // interrupt mask, index

  // ********
  // control register fields
  // ********
  localparam int CTL_EN     = 7;  // xfer_enable / master_xfer_enable
  localparam int CTL_SIZE   = 6;  // xfer_size (short layout)
  localparam int CTL_DIR    = 5;  // addr_step_dir / dest_step_dir
  localparam int CTL_RPT    = 4;  // repeat_en / dest_step_en
  localparam int CTL_IRQEN  = 3;  // xfer_irq_en / block side select
  localparam int CTL_SEL_HI = 2;  // activation select msb
  localparam int CTL_SEL_LO = 0;  // activation select lsb

  // ********
  // reset values
  // ********
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [7:0]  IOADDR_RST = 8'h00;
  localparam logic [23:0] MADDR_RST  = 24'h000000;
  localparam logic [1:0]  IRQ_RST    = 2'h0;

  // ********
  // interrupt status bits
  // ********
  localparam int ST_END    = 0;  // hardware ended the transfer
  localparam int ST_BADSEL = 1;  // unavailable activation code armed
  localparam int ST_W      = 2;

  // ********
  // activation codes
  // ********
  typedef logic [2:0] dmab_sel_t;
  localparam dmab_sel_t ACT_AUTO_BURST = 3'h0;
  localparam dmab_sel_t ACT_AUTO_STEAL = 3'h2;
  localparam dmab_sel_t ACT_TX_EMPTY   = 3'h4;
  localparam dmab_sel_t ACT_RX_FULL    = 3'h5;
  localparam dmab_sel_t ACT_REQ_FALL   = 3'h6;
  localparam dmab_sel_t ACT_REQ_LOW    = 3'h7;
  localparam logic [1:0] ACT_A_FULL    = 2'h3;  // channel a upper bits

  typedef enum logic [1:0] {MODE_IO, MODE_REPEAT, MODE_IDLE} dmab_mode_e;

  // repeat and interrupt enables together pick the short mode
  function automatic dmab_mode_e dmab_mode(input logic rpt, input logic irq_en);
    if (!rpt)
      return MODE_IO;
    else if (!irq_en)
      return MODE_REPEAT;
    else
      return MODE_IDLE;
  endfunction

  // next address after one transfer: 1 per byte, 2 per word
  function automatic logic [23:0] dmab_step(input logic [23:0] addr,
                                            input logic word, input logic dec);
    logic [23:0] amt;
    amt = word ? 24'h000002 : 24'h000001;
    return dec ? addr - amt : addr + amt;
  endfunction

endpackage

// ---- rtl/dmab_req_sync.sv ----
// synchroniser and edge detector for the external request pin
`timescale 1ns/100ps
module dmab_req_sync
(
  input  wire logic clk,                 // system clock
  input  wire logic reset_n,             // async reset, active low
  input  wire logic ext_xfer_request_n,  // request pin, active low
  output logic      req_fall_q,          // one-cycle pulse on falling edge
  output logic      req_low_q            // level, pin held low
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // two flops before any logic looks at the pin; idle level is high
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end
    else
    begin
      meta_q <= ext_xfer_request_n;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // edge and level taken only from the settled copy
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      req_fall_q <= 1'b0;
      req_low_q  <= 1'b0;
    end
    else
    begin
      req_fall_q <= prev_q & ~sync_q;
      req_low_q  <= ~sync_q;
    end
  end

endmodule // dmab_req_sync

// ---- rtl/dmab_ctrl.sv ----
// channel b control registers, activation select and address stepping
// Operation
// - short mode uses i/o address register as fixed address; full mode ignores it
// - short codes 0xx start on timer_unit channel 0..3 compare/capture a
// - short code 100 starts on serial tx empty, 101 on rx full
// - short code 110 falling request edge starts, 111 low level requests
// - with irq enable set, hardware clearing xfer_enable raises an interrupt
// - short mode steps address by 1 or 2, direction bit picks up/down
// - channel b transfers run only while xfer_enable is 1
// - full mode bit 7 is master enable for the channel pair
// - full normal code 000 is auto-request burst
// - full normal code 010 is auto-request cycle steal; 001,011,100,101 unavailable
// - full block codes 000..011 start on timer channel 0..3; 110 on falling edge
// - full code 111 level request only in normal mode, not in block mode
// - block side select 0 makes destination the block, 1 the source
// - full mode destination fixed when step disabled, else increments by 1 or 2
// - full mode step enabled with direction 1 decrements by 1 or 2
// - full layout applies when channel a select upper two bits are 11
//
// The Wishbone slave port was decided locally.
`timescale 1ns/100ps
module dmab_ctrl
  import dmab_pkg::*;
(
  input  wire logic                    clk,                // 25 MHz system clock
  input  wire logic                    reset_n,            // async reset, active low
  input  wire logic                    wb_cyc_i,           // wishbone cycle
  input  wire logic                    wb_stb_i,           // wishbone strobe
  input  wire logic                    wb_we_i,            // wishbone write
  input  wire logic [dmab_pkg::WB_AW-1:0] wb_adr_i,        // byte address
  input  wire logic [3:0]              wb_sel_i,           // byte lanes
  input  wire logic [dmab_pkg::WB_DW-1:0] wb_dat_i,        // write data
  output logic [dmab_pkg::WB_DW-1:0]   wb_dat_o,           // read data
  output logic                         wb_ack_o,           // wishbone ack
  input  wire logic [2:0]              chan_a_act_sel,     // channel a select code
  input  wire logic                    chan_a_block_mode,  // channel a block mode
  input  wire logic                    chan_a_word_size,   // channel a size, full mode
  input  wire logic [3:0]              timer_unit_match,   // timer ch 0..3 pulses
  input  wire logic                    serial_tx_empty,    // serial tx empty pulse
  input  wire logic                    serial_rx_full,     // serial rx full pulse
  input  wire logic                    ext_xfer_request_n, // request pin, active low
  input  wire logic                    xfer_done,          // one transfer finished
  output logic                         xfer_req_q,         // transfer request level
  output logic                         xfer_burst_q,       // burst, not cycle steal
  output logic                         xfer_word_q,        // word-size transfer
  output logic [23:0]                  xfer_addr_q,        // memory address
  output logic [7:0]                   io_addr_b_q,        // fixed i/o address
  output logic                         full_mode_q,        // full address layout
  output logic                         block_src_q,        // source is block area
  output logic                         irq_q               // interrupt, active high
);

  // ********
  // declarations
  // ********
  logic [7:0]      ctrl_q;
  logic [15:0]     count_q;
  logic [7:0]      io_addr_q;
  logic [23:0]     maddr_q;
  logic [ST_W-1:0] stat_q;
  logic [ST_W-1:0] mask_q;
  logic            ack_q;
  logic [31:0]     rdat_q;
  logic            req_pend_q;
  logic            req_fall;
  logic            req_low;
  logic            bus_hit;
  logic            bus_wr;
  logic            bus_rd;
  logic [7:0]      idx;
  logic            full;
  dmab_mode_e      mode;
  dmab_sel_t       sel;
  logic            enabled;
  logic            edge_start;
  logic            level_req;
  logic            bad_sel;
  logic            size_word;
  logic            step_on;
  logic            count_end;
  logic            hw_clear;
  logic [15:0]     count_nx;

  // byte address is four times the index
  function automatic logic wb_at(input logic [7:0] a, input logic [7:0] i);
    return a == {i[5:0], 2'b00};
  endfunction

  // ********
  // external request pin
  // ********
  dmab_req_sync u_req_sync
  (
    .clk                (clk),
    .reset_n            (reset_n),
    .ext_xfer_request_n (ext_xfer_request_n),
    .req_fall_q         (req_fall),
    .req_low_q          (req_low)
  );

  // ********
  // wishbone slave
  // ********
  // ack one cycle after the strobe, dropped the cycle after
  assign bus_hit = wb_cyc_i & wb_stb_i & ack_q;
  assign bus_wr  = bus_hit & wb_we_i;
  assign bus_rd  = bus_hit & ~wb_we_i;
  assign idx     = wb_adr_i;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ack_q <= 1'b0;
    else
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
  end

  // read data registered with the ack; unmapped reads return zero
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rdat_q <= 32'h00000000;
    else if (wb_cyc_i & wb_stb_i & ~ack_q)
    begin
      rdat_q <= 32'h00000000;
      if (wb_at(idx, IDX_COUNT))
        rdat_q <= {16'h0000, count_q};
      else if (wb_at(idx, IDX_IOADDR))
        rdat_q <= {24'h000000, io_addr_q};
      else if (wb_at(idx, IDX_CTRL))
        rdat_q <= {24'h000000, ctrl_q};
      else if (wb_at(idx, IDX_MADDR))
        rdat_q <= {8'h00, maddr_q};
      else if (wb_at(idx, IDX_STAT))
        rdat_q <= {30'h00000000, stat_q};
      else if (wb_at(idx, IDX_MASK))
        rdat_q <= {30'h00000000, mask_q};
    end
  end

  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;

  // ********
  // mode decode
  // ********
  assign full      = chan_a_act_sel[2:1] == ACT_A_FULL;
  assign sel       = ctrl_q[CTL_SEL_HI:CTL_SEL_LO];
  assign mode      = dmab_mode(ctrl_q[CTL_RPT], ctrl_q[CTL_IRQEN]);
  assign enabled   = ctrl_q[CTL_EN];
  assign size_word = full ? chan_a_word_size : ctrl_q[CTL_SIZE];

  // activation select: edge sources set a pending request
  always_comb
  begin
    edge_start = 1'b0;
    level_req  = 1'b0;
    bad_sel    = 1'b0;
    if (!full)
    begin
      if (!sel[2])
        edge_start = timer_unit_match[sel[1:0]];
      else
        unique case (sel)
          ACT_TX_EMPTY: edge_start = serial_tx_empty;
          ACT_RX_FULL:  edge_start = serial_rx_full;
          ACT_REQ_FALL: edge_start = req_fall;
          default:      level_req  = req_low;
        endcase
    end
    else if (chan_a_block_mode)
    begin
      if (!sel[2])
        edge_start = timer_unit_match[sel[1:0]];
      else if (sel == ACT_REQ_FALL)
        edge_start = req_fall;
      else
        bad_sel = 1'b1;
    end
    else
    begin
      unique case (sel)
        ACT_AUTO_BURST: level_req  = 1'b1;
        ACT_AUTO_STEAL: level_req  = 1'b1;
        ACT_REQ_FALL:   edge_start = req_fall;
        ACT_REQ_LOW:    level_req  = req_low;
        default:        bad_sel    = 1'b1;
      endcase
    end
  end

  // ********
  // count and end of transfer
  // ********
  // short i/o mode alone ends itself; full mode count is kept by channel a
  assign step_on   = enabled & xfer_done;
  assign count_nx  = (mode == MODE_IO) ? count_q - 16'h0001
                   : {count_q[15:8], count_q[7:0] - 8'h01};
  assign count_end = (mode == MODE_IO) ? count_q == 16'h0001 : count_q[7:0] == 8'h01;
  assign hw_clear  = step_on & ~full & (mode == MODE_IO) & count_end;

  // ********
  // registers written by software
  // ********
  // control fields reset to zero; hardware end clears the enable bit
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ctrl_q <= CTRL_RST;
    else if (bus_wr & wb_at(idx, IDX_CTRL) & wb_sel_i[0])
      ctrl_q <= wb_dat_i[7:0];
    else if (hw_clear)
      ctrl_q[CTL_EN] <= 1'b0;
  end

  // undefined after reset on the part; zero chosen so outputs are clean
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      io_addr_q <= IOADDR_RST;
    else if (bus_wr & wb_at(idx, IDX_IOADDR) & wb_sel_i[0])
      io_addr_q <= wb_dat_i[7:0];
  end

  // count: repeat and idle reload the low byte from the high byte
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      count_q <= COUNT_RST;
    else if (bus_wr & wb_at(idx, IDX_COUNT))
    begin
      if (wb_sel_i[0])
        count_q[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1])
        count_q[15:8] <= wb_dat_i[15:8];
    end
    else if (step_on & ~full)
    begin
      if (mode != MODE_IO && count_end)
        count_q[7:0] <= count_q[15:8];
      else
        count_q <= count_nx;
    end
  end

  // address steps after each transfer; idle mode and fixed dest hold
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      maddr_q <= MADDR_RST;
    else if (bus_wr & wb_at(idx, IDX_MADDR))
    begin
      if (wb_sel_i[0])
        maddr_q[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1])
        maddr_q[15:8] <= wb_dat_i[15:8];
      if (wb_sel_i[2])
        maddr_q[23:16] <= wb_dat_i[23:16];
    end
    else if (step_on & ~full & (mode != MODE_IDLE))
      maddr_q <= dmab_step(maddr_q, size_word, ctrl_q[CTL_DIR]);
    else if (step_on & full & ctrl_q[CTL_RPT])
      maddr_q <= dmab_step(maddr_q, size_word, ctrl_q[CTL_DIR]);
  end

  // ********
  // request generation
  // ********
  // pending edge request; a new edge in the done cycle wins
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      req_pend_q <= 1'b0;
    else if (!enabled)
      req_pend_q <= 1'b0;
    else if (edge_start)
      req_pend_q <= 1'b1;
    else if (xfer_done)
      req_pend_q <= 1'b0;
  end

  // outputs straight from flops; request held off when disabled
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      xfer_req_q   <= 1'b0;
      xfer_burst_q <= 1'b0;
      xfer_word_q  <= 1'b0;
      full_mode_q  <= 1'b0;
      block_src_q  <= 1'b0;
    end
    else
    begin
      xfer_req_q   <= enabled & ~hw_clear & (req_pend_q | edge_start | level_req);
      xfer_burst_q <= full & ~chan_a_block_mode & (sel == ACT_AUTO_BURST);
      xfer_word_q  <= size_word;
      full_mode_q  <= full;
      block_src_q  <= full & chan_a_block_mode & ctrl_q[CTL_IRQEN];
    end
  end

  // address outputs; the i/o address is meaningless in full mode
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      xfer_addr_q <= MADDR_RST;
      io_addr_b_q <= IOADDR_RST;
    end
    else
    begin
      xfer_addr_q <= maddr_q;
      io_addr_b_q <= full ? IOADDR_RST : io_addr_q;
    end
  end

  // ********
  // interrupts
  // ********
  // sticky status, cleared by a read; a set in the same cycle wins
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      stat_q <= IRQ_RST;
    else
    begin
      if (bus_rd & wb_at(idx, IDX_STAT))
        stat_q <= IRQ_RST;
      if (hw_clear & ctrl_q[CTL_IRQEN])
        stat_q[ST_END] <= 1'b1;
      if (enabled & bad_sel)
        stat_q[ST_BADSEL] <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      mask_q <= IRQ_RST;
    else if (bus_wr & wb_at(idx, IDX_MASK) & wb_sel_i[0])
      mask_q <= wb_dat_i[ST_W-1:0];
  end

  // level interrupt while any unmasked status bit stands
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_q <= 1'b0;
    else
      irq_q <= |(stat_q & mask_q);
  end

endmodule // dmab_ctrl

// ---- sim/dmab_ctrl_properties.sv ----
// port-level assertions for the channel b control block
`timescale 1ns/100ps
module dmab_ctrl_properties
  import dmab_pkg::*;
(
  input wire logic                        clk,               // clock
  input wire logic                        reset_n,           // reset, active low
  input wire logic                        wb_cyc_i,          // bus cycle
  input wire logic                        wb_stb_i,          // bus strobe
  input wire logic                        wb_we_i,           // bus write
  input wire logic [dmab_pkg::WB_AW-1:0]  wb_adr_i,          // byte address
  input wire logic [3:0]                  wb_sel_i,          // byte lanes
  input wire logic [dmab_pkg::WB_DW-1:0]  wb_dat_i,          // write data
  input wire logic                        wb_ack_o,          // bus ack
  input wire logic [2:0]                  chan_a_act_sel,    // channel a code
  input wire logic                        chan_a_block_mode, // block mode
  input wire logic                        chan_a_word_size,  // full mode size
  input wire logic [3:0]                  timer_unit_match,  // timer pulses
  input wire logic                        serial_tx_empty,   // tx empty pulse
  input wire logic                        serial_rx_full,    // rx full pulse
  input wire logic                        xfer_done,         // transfer finished
  input wire logic                        xfer_req_q,        // request level
  input wire logic [23:0]                 xfer_addr_q,       // memory address
  input wire logic [7:0]                  io_addr_b_q,       // fixed i/o address
  input wire logic                        full_mode_q,       // full layout
  input wire logic                        block_src_q,       // block is source
  input wire logic                        irq_q              // interrupt
);
  logic [7:0]  ctrl_q;
  logic [23:0] amt_s;
  logic [23:0] amt_f;
  logic        bad_code;
  logic        sel_a_full;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // shadow of the last control write; hardware clears are not seen
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ctrl_q <= 8'h00;
    else if (wb_cyc_i && wb_ack_o && wb_we_i && wb_adr_i == (IDX_CTRL << 2) && wb_sel_i[0])
      ctrl_q <= wb_dat_i[7:0];
  end

  // step sizes, and codes that may never raise a request
  assign amt_s = ctrl_q[CTL_SIZE] ? 24'h000002 : 24'h000001;
  assign amt_f = chan_a_word_size ? 24'h000002 : 24'h000001;
  assign sel_a_full = (chan_a_act_sel[2:1] == ACT_A_FULL);
  assign bad_code = full_mode_q && (chan_a_block_mode ? ctrl_q[2:0] inside {3'h4, 3'h5, 3'h7}
                                    : ctrl_q[2:0] inside {3'h1, 3'h3, 3'h4, 3'h5});

  sequence s_req_seen;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_short_on;
    !full_mode_q && ctrl_q[CTL_EN];
  endsequence

  ack_answer_a: assert property (s_req_seen |=> wb_ack_o) else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  io_addr_full_a: assert property (full_mode_q && $past(full_mode_q) |-> io_addr_b_q == 8'h00)
    else $error("io addr in full");
  full_layout_a: assert property ($past(reset_n) |-> full_mode_q == $past(sel_a_full))
    else $error("layout wrong");
  enable_gate_a: assert property (!ctrl_q[CTL_EN] [*2] |-> !xfer_req_q)
    else $error("req disabled");
  timer_start_a: assert property (s_short_on ##0 (!ctrl_q[2] && timer_unit_match[ctrl_q[1:0]])
    |=> xfer_req_q) else $error("timer event lost");
  serial_start_a: assert property (s_short_on ##0 ((ctrl_q[2:0] == ACT_TX_EMPTY && serial_tx_empty)
    || (ctrl_q[2:0] == ACT_RX_FULL && serial_rx_full)) |=> xfer_req_q) else $error("serial lost");
  short_step_a: assert property (s_short_on ##0 (xfer_done && !(ctrl_q[CTL_RPT] && ctrl_q[CTL_IRQEN]))
    |=> ##1 xfer_addr_q == (ctrl_q[CTL_DIR] ? $past(xfer_addr_q) - amt_s : $past(xfer_addr_q) + amt_s))
    else $error("short step");
  full_step_a: assert property (full_mode_q && ctrl_q[CTL_EN] && xfer_done |=> ##1 xfer_addr_q ==
    (!ctrl_q[CTL_RPT] ? $past(xfer_addr_q) : ctrl_q[CTL_DIR] ? $past(xfer_addr_q) - amt_f
    : $past(xfer_addr_q) + amt_f)) else $error("dest step");
  bad_code_a: assert property (bad_code [*2] |-> !xfer_req_q)
    else $error("bad code req");
  block_side_a: assert property ((full_mode_q && chan_a_block_mode && $stable(ctrl_q)) [*2]
    |-> block_src_q == ctrl_q[CTL_IRQEN]) else $error("block side wrong");
  reset_quiet_a: assert property ($rose(reset_n) |-> !xfer_req_q && !irq_q && !full_mode_q)
    else $error("reset outputs");
endmodule // dmab_ctrl_properties

bind dmab_ctrl dmab_ctrl_properties u_props (.*);

// ---- sim/dmab_req_partner.sv ----
// far-side device driving the active-low transfer request pin
`timescale 1ns/100ps
module dmab_req_partner
#(
  parameter int PULSE = 3                 // low cycles per edge request
)
(
  input  wire logic clk,                  // system clock
  input  wire logic pulse_go,             // start one low pulse
  input  wire logic hold_low,             // hold the pin low
  output logic      ext_xfer_request_n    // request pin, active low
);
  int unsigned low_left = 0;

  // a short low pulse gives an edge; a steady low is a level request
  always @(posedge clk)
  begin
    if (pulse_go)
      low_left <= PULSE;
    else if (low_left != 0)
      low_left <= low_left - 1;
  end
  assign ext_xfer_request_n = !(hold_low || low_left != 0);
endmodule // dmab_req_partner

// ---- sim/test_dma_channel_b_control.sv ----
// self-checking bench for the channel b control block
`timescale 1ns/100ps
module test_dma_channel_b_control;
  import dmab_pkg::*;
  localparam logic [7:0] A_CNT = IDX_COUNT << 2, A_IO = IDX_IOADDR << 2, A_CTL = IDX_CTRL << 2;
  localparam logic [7:0] A_MAD = IDX_MADDR << 2, A_STA = IDX_STAT << 2, A_MSK = IDX_MASK << 2;
  logic        clk = 1'b0;
  logic        reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, chan_a_block_mode;
  logic        chan_a_word_size, serial_tx_empty, serial_rx_full, xfer_done, pulse_go, hold_low;
  logic        ext_xfer_request_n, xfer_req_q, xfer_burst_q, xfer_word_q, full_mode_q;
  logic        block_src_q, irq_q;
  logic [7:0]  wb_adr_i, io_addr_b_q;
  logic [3:0]  wb_sel_i, timer_unit_match;
  logic [2:0]  chan_a_act_sel;
  logic [31:0] wb_dat_i, wb_dat_o, rdat;
  logic [23:0] xfer_addr_q, ea;
  int          fails = 0;
  int          samples_checked = 0;
  // flags: 0 req, 1 burst, 2 full, 3 block source, 4 irq, 5 word, 15:8 i/o address
  wire  [31:0] obs = {16'h0, io_addr_b_q, 2'h0, xfer_word_q, irq_q, block_src_q, full_mode_q,
                      xfer_burst_q, xfer_req_q};

  dmab_ctrl dut (.*);
  dmab_req_partner u_pin (.clk, .pulse_go, .hold_low, .ext_xfer_request_n);

  always #20 clk = ~clk;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic test_done;
    $display("compares %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // classic single cycle; ack sampled on rising edges, bounded wait
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      fails++;
      test_done();
    end
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(rdat, e);
  endtask

  // masked flags at mid-cycle
  task automatic chkn(input logic [31:0] m, input logic [31:0] e);
    @(negedge clk);
    chk(obs & m, e);
    @(posedge clk);
  endtask

  // request level within lim cycles
  task automatic look(input logic v, input int lim);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (xfer_req_q !== v && n < lim);
    chk({31'h0, xfer_req_q}, {31'h0, v});
    if (xfer_req_q !== v)
      test_done();
    @(posedge clk);
  endtask

  // one-cycle event: 0..3 timer channel, 4 tx empty, 5 rx full
  task automatic fire(input int s);
    {serial_rx_full, serial_tx_empty, timer_unit_match} <= 6'h01 << s;
    @(posedge clk);
    {serial_rx_full, serial_tx_empty, timer_unit_match} <= 6'h00;
  endtask

  // finish one transfer, address lands two edges later
  task automatic step(input logic [23:0] e);
    xfer_done <= 1'b1;
    @(posedge clk);
    xfer_done <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk({8'h0, xfer_addr_q}, {8'h0, e});
    @(posedge clk);
  endtask

  task automatic t_reset;
    chkn(32'h0000003D, 32'h0);
    rd(A_CTL, 32'h0);
    rd(A_MSK, 32'h0);
    bus(8'hFC, 1'b1, 32'hFFFFFFFF);
    rd(8'hFC, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_short;
    logic [7:0] c;
    ea = 24'h001000;
    bus(A_IO, 1'b1, 32'hA5);
    chkn(32'h0000FF00, 32'h0000A500);
    bus(A_MAD, 1'b1, {8'h0, ea});
    bus(A_CNT, 1'b1, 32'h0100);
    for (int k = 0; k < 4; k++)
    begin
      c = {1'b1, k[0], k[1], 3'h0, k[1:0]};
      bus(A_CTL, 1'b1, {24'h0, c});
      fire((k + 1) % 4);
      look(1'b0, 1);
      fire(k);
      look(1'b1, 1);
      ea = k[1] ? ea - (k[0] ? 24'h2 : 24'h1) : ea + (k[0] ? 24'h2 : 24'h1);
      step(ea);
    end
    for (int s = 4; s < 6; s++)
    begin
      bus(A_CTL, 1'b1, {29'h0, s[2:0]} | 32'h80);
      fire(9 - s);
      look(1'b0, 1);
      fire(s);
      look(1'b1, 1);
      ea = ea + 24'h1;
      step(ea);
    end
    $display("test short done");
  endtask

  task automatic t_ext;
    bus(A_CTL, 1'b1, 32'h07);
    hold_low <= 1'b1;
    repeat (6) @(posedge clk);
    look(1'b0, 1);
    bus(A_CTL, 1'b1, 32'h87);
    look(1'b1, 8);
    hold_low <= 1'b0;
    ea = ea + 24'h1;
    step(ea);
    look(1'b0, 8);
    bus(A_CTL, 1'b1, 32'h86);
    pulse_go <= 1'b1;
    @(posedge clk);
    pulse_go <= 1'b0;
    look(1'b1, 8);
    ea = ea + 24'h1;
    step(ea);
    look(1'b0, 1);
    $display("test request pin done");
  endtask

  task automatic t_irq;
    for (int i = 0; i < 3; i++)
    begin
      bus(A_MSK, 1'b1, {31'h0, i != 1});
      bus(A_CNT, 1'b1, 32'h0001);
      bus(A_CTL, 1'b1, (i != 2) ? 32'h88 : 32'h80);
      fire(0);
      look(1'b1, 1);
      ea = ea + 24'h1;
      step(ea);
      rd(A_CTL, (i != 2) ? 32'h08 : 32'h00);
      chkn(32'h10, {27'h0, i == 0, 4'h0});
      rd(A_STA, {31'h0, i != 2});
      chkn(32'h10, 32'h0);
    end
    bus(A_CNT, 1'b1, 32'h0201);
    bus(A_CTL, 1'b1, 32'h90);
    fire(0);
    look(1'b1, 1);
    ea = ea + 24'h1;
    step(ea);
    rd(A_CNT, 32'h0202);
    rd(A_CTL, 32'h90);
    bus(A_CTL, 1'b1, 32'h98);
    fire(0);
    look(1'b1, 1);
    step(ea);
    $display("test interrupt done");
  endtask

  task automatic t_full;
    chan_a_act_sel <= 3'h6;
    chan_a_word_size <= 1'b1;
    bus(A_CTL, 1'b1, 32'h00);
    chkn(32'h0000FF04, 32'h4);
    look(1'b0, 1);
    bus(A_CTL, 1'b1, 32'h90);
    chkn(32'h23, 32'h23);
    ea = ea + 24'h2;
    step(ea);
    bus(A_CTL, 1'b1, 32'hB2);
    chkn(32'h3, 32'h1);
    ea = ea - 24'h2;
    step(ea);
    bus(A_CTL, 1'b1, 32'h81);
    look(1'b0, 1);
    rd(A_STA, 32'h2);
    chan_a_block_mode <= 1'b1;
    bus(A_CTL, 1'b1, 32'h8F);
    hold_low <= 1'b1;
    repeat (6) @(posedge clk);
    look(1'b0, 1);
    chkn(32'h8, 32'h8);
    hold_low <= 1'b0;
    bus(A_CTL, 1'b1, 32'h81);
    fire(1);
    look(1'b1, 1);
    step(ea);
    chkn(32'h8, 32'h0);
    chan_a_block_mode <= 1'b0;
    bus(A_CTL, 1'b1, 32'h87);
    hold_low <= 1'b1;
    look(1'b1, 8);
    hold_low <= 1'b0;
    step(ea);
    $display("test full layout done");
  endtask

  // reset for four cycles, then the scenarios in turn
  initial
  begin
    {reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, chan_a_act_sel} = '0;
    {chan_a_block_mode, chan_a_word_size, timer_unit_match, serial_tx_empty} = '0;
    {serial_rx_full, xfer_done, pulse_go, hold_low} = '0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_short();
    t_ext();
    t_irq();
    t_full();
    test_done();
  end
endmodule // test_dma_channel_b_control
